// ---- common/dsp_pkg.sv ----
// How it works
// - device is target only, never drives clock
// - address is fixed six bits plus select pin
// - write address byte 74h or 76h
// - read address byte 75h or 77h
// - write: address, register, data stores data
// - read: address, register, address read, data
// - any count of sequential bytes, pointer increments
// - host stops after all bytes moved, or early on a nack
// - host clock never above 400 kHz
// - data byte goes to register addressed before
// - every register reads back what was written
// - writes only while reset pin is high
// - port and registers survive sleep mode
package dsp_pkg;

   // bus addressing
   localparam logic [5:0] ADDR_HI    = 6'h1d;
   localparam logic [7:0] WR_BYTE_LO = 8'h74;
   localparam logic [7:0] WR_BYTE_HI = 8'h76;
   localparam logic [7:0] RD_BYTE_LO = 8'h75;
   localparam logic [7:0] RD_BYTE_HI = 8'h77;

   // register file
   localparam int         REG_COUNT = 256;
   localparam logic [7:0] REG_RST   = 8'h00;

   // bit timing
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         SCL_MAX_KHZ   = 400;
   localparam int         SCL_MIN_NS    = 1000000 / SCL_MAX_KHZ;
   localparam int         QUARTER_INT   =
      (SCL_MIN_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam logic [6:0] QUARTER_CYC   = 7'(QUARTER_INT);
   localparam logic [3:0] ACK_BIT       = 4'h8;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_MACK
   } dev_state_t;

   typedef enum logic [2:0] {
      H_IDLE, H_START, H_BYTE, H_STOP
   } host_state_t;

   typedef enum logic [2:0] {
      P_AW, P_REG, P_WD, P_AR, P_RD
   } host_phase_t;

   // full address byte for a select level and direction
   function automatic logic [7:0] addr_byte(input logic sel,
                                            input logic rnw);
      case ({sel, rnw})
         2'b00:   addr_byte = WR_BYTE_LO;
         2'b10:   addr_byte = WR_BYTE_HI;
         2'b01:   addr_byte = RD_BYTE_LO;
         default: addr_byte = RD_BYTE_HI;
      endcase
   endfunction

endpackage

// ---- common/serial_if.sv ----
`timescale 1ns/1ps
interface serial_if;
   // open-drain drivers: oe high pulls the wire low
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   // resolved wire levels with pull-ups
   logic scl;
   logic sda;

   assign scl = ~(host_scl_oe & ~host_scl_out);
   assign sda = ~((host_sda_oe & ~host_sda_out) |
                  (dev_sda_oe & ~dev_sda_out));

   modport host (output host_scl_out, host_scl_oe,
                 output host_sda_out, host_sda_oe,
                 input  scl, sda);
   modport dev  (output dev_sda_out, dev_sda_oe,
                 input  scl, sda);
endinterface

// ---- src/disp_port_dev.sv ----
`timescale 1ns/1ps
module disp_port_dev
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_reset,
   // serial link
   serial_if.dev     bus,
   // device pins
   input  wire logic i_addr_select_pin,
   input  wire logic i_pin_reset_low,
   input  wire logic i_sleep_request,
   // register write notice
   output logic       o_reg_wr,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_data,
   // status
   output logic       o_sleep_active,
   output logic       o_busy
);
   typedef struct packed {
      dev_state_t state;
      logic [3:0] bits;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic       have_reg;
      logic       rnw;
      logic       sda_oe;
      logic       wr;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic       sleep;
      logic       busy;
   } dev_ff_t;

   dev_ff_t    s_ff;
   dev_ff_t    nxt_s;
   logic [7:0] regs [REG_COUNT];
   logic [4:0] lvl;
   logic [4:0] rise;
   logic [4:0] fall;
   logic       scl_lvl;
   logic       sda_lvl;
   logic       sel_lvl;
   logic       rst_lvl;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;
   logic       mem_we;
   logic [7:0] rd_byte;

   // all pins cross from outside through two flops
   pin_sync #(
      .WIDTH (5)
   ) u_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_pin   ({bus.scl, bus.sda, i_addr_select_pin,
                 i_pin_reset_low, i_sleep_request}),
      .o_level (lvl),
      .o_rise  (rise),
      .o_fall  (fall)
   );

   // pin roles
   assign scl_lvl    = lvl[4];
   assign sda_lvl    = lvl[3];
   assign sel_lvl    = lvl[2];
   assign rst_lvl    = lvl[1];
   assign scl_rise   = rise[4];
   assign scl_fall   = fall[4];
   assign start_cond = fall[3] & scl_lvl;
   assign stop_cond  = rise[3] & scl_lvl;
   assign rd_byte    = regs[s_ff.ptr];

   // protocol engine; data moves on scl edges only
   always_comb begin
      nxt_s       = s_ff;
      nxt_s.wr    = 1'b0;
      nxt_s.sleep = lvl[0]; // no effect on the port
      mem_we      = 1'b0;
      if (!rst_lvl) begin
         // reset pin low: port idle, nothing stored
         nxt_s.state  = S_IDLE;
         nxt_s.sda_oe = 1'b0;
      end else if (start_cond) begin
         // fresh or repeated start; pointer survives
         nxt_s.state  = S_ADDR;
         nxt_s.bits   = 4'h0;
         nxt_s.sda_oe = 1'b0;
      end else if (stop_cond) begin
         nxt_s.state  = S_IDLE;
         nxt_s.sda_oe = 1'b0;
      end else begin
         case (s_ff.state)
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  nxt_s.shift = {s_ff.shift[6:0], sda_lvl};
                  nxt_s.bits  = s_ff.bits + 4'h1;
               end else if (scl_fall && s_ff.bits == ACK_BIT) begin
                  if (s_ff.state == S_ADDR) begin
                     if (s_ff.shift[7:1] == {ADDR_HI, sel_lvl}) begin
                        // own address: ack it
                        nxt_s.sda_oe = 1'b1;
                        nxt_s.rnw    = s_ff.shift[0];
                        nxt_s.state  = S_ACK;
                        if (!s_ff.shift[0]) begin
                           nxt_s.have_reg = 1'b0;
                        end
                     end else begin
                        // not ours: stay off the bus
                        nxt_s.state = S_IDLE;
                     end
                  end else if (!s_ff.have_reg) begin
                     // first byte selects the register
                     nxt_s.ptr      = s_ff.shift;
                     nxt_s.have_reg = 1'b1;
                     nxt_s.sda_oe   = 1'b1;
                     nxt_s.state    = S_ACK;
                  end else begin
                     // store, then step to next register
                     mem_we        = 1'b1;
                     nxt_s.wr      = 1'b1;
                     nxt_s.wr_addr = s_ff.ptr;
                     nxt_s.wr_data = s_ff.shift;
                     nxt_s.ptr     = s_ff.ptr + 8'h01;
                     nxt_s.sda_oe  = 1'b1;
                     nxt_s.state   = S_ACK;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  nxt_s.bits = 4'h0;
                  if (s_ff.rnw) begin
                     // load and present msb of register
                     nxt_s.shift  = rd_byte;
                     nxt_s.sda_oe = ~rd_byte[7];
                     nxt_s.ptr    = s_ff.ptr + 8'h01;
                     nxt_s.state  = S_TX;
                  end else begin
                     nxt_s.sda_oe = 1'b0;
                     nxt_s.state  = S_RX;
                  end
               end
            end
            S_TX: begin
               if (scl_rise) begin
                  nxt_s.bits = s_ff.bits + 4'h1;
               end else if (scl_fall) begin
                  if (s_ff.bits == ACK_BIT) begin
                     nxt_s.sda_oe = 1'b0; // free line for host ack
                     nxt_s.state  = S_MACK;
                  end else begin
                     nxt_s.shift  = {s_ff.shift[6:0], 1'b0};
                     nxt_s.sda_oe = ~s_ff.shift[6];
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  // host ack: next byte on the following fall
                  nxt_s.state = sda_lvl ? S_IDLE : S_ACK;
               end
            end
            default: begin
               nxt_s.sda_oe = 1'b0;
            end
         endcase
      end
      nxt_s.busy = (nxt_s.state != S_IDLE);
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s_ff       <= '0;
         s_ff.state <= S_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // register array; only reset clears it, never sleep
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= REG_RST;
         end
      end else if (mem_we) begin
         regs[s_ff.ptr] <= s_ff.shift;
      end
   end

   // device only ever pulls sda low, never scl
   assign bus.dev_sda_out = 1'b0;
   assign bus.dev_sda_oe  = s_ff.sda_oe;

   assign o_reg_wr       = s_ff.wr;
   assign o_reg_addr     = s_ff.wr_addr;
   assign o_reg_data     = s_ff.wr_data;
   assign o_sleep_active = s_ff.sleep;
   assign o_busy         = s_ff.busy;
endmodule // disp_port_dev

// ---- src/disp_port_host.sv ----
`timescale 1ns/1ps
module disp_port_host
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_reset,
   // serial link
   serial_if.host          bus,
   // command
   input  wire logic       i_go,
   input  wire logic       i_rnw,
   input  wire logic       i_addr_select,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_len,
   input  wire logic [7:0] i_wr_data,
   // answer
   output logic            o_busy,
   output logic            o_done,
   output logic            o_nack,
   output logic            o_wr_take,
   output logic            o_rd_valid,
   output logic [7:0]      o_rd_data
);
   typedef struct packed {
      host_state_t state;
      host_phase_t phase;
      logic [1:0]  q;
      logic [6:0]  cnt;
      logic [3:0]  bits;
      logic [7:0]  shift;
      logic [7:0]  left;
      logic [7:0]  reg_a;
      logic        rnw;
      logic        sel;
      logic        scl_oe;
      logic        sda_oe;
      logic        busy;
      logic        done;
      logic        nack;
      logic        take;
      logic        rd_valid;
      logic [7:0]  rd_data;
   } host_ff_t;

   host_ff_t s_ff;
   host_ff_t nxt_s;
   logic     sda_lvl;
   logic     rx;
   logic     last;

   // sda read back from the wire, two flops first
   pin_sync #(
      .WIDTH (1)
   ) u_sync (
      .i_clock (i_clock),
      .i_reset (i_reset),
      .i_pin   (bus.sda),
      .o_level (sda_lvl),
      .o_rise  (),
      .o_fall  ()
   );

   assign rx   = (s_ff.phase == P_RD);
   assign last = (s_ff.left == 8'h01);

   // four quarters per bit keep scl at or below 400 kHz
   always_comb begin
      nxt_s          = s_ff;
      nxt_s.done     = 1'b0;
      nxt_s.take     = 1'b0;
      nxt_s.rd_valid = 1'b0;
      if (s_ff.state == H_IDLE) begin
         if (i_go) begin
            nxt_s.state = H_START;
            nxt_s.phase = P_AW;
            nxt_s.q     = 2'h0;
            nxt_s.cnt   = 7'h00;
            nxt_s.rnw   = i_rnw;
            nxt_s.sel   = i_addr_select;
            nxt_s.reg_a = i_reg_addr;
            nxt_s.left  = (i_len == 8'h00) ? 8'h01 : i_len;
            nxt_s.busy  = 1'b1;
            nxt_s.nack  = 1'b0;
         end
      end else if (s_ff.cnt != QUARTER_CYC - 7'h01) begin
         nxt_s.cnt = s_ff.cnt + 7'h01;
      end else begin
         nxt_s.cnt = 7'h00;
         nxt_s.q   = s_ff.q + 2'h1;
         case (s_ff.state)
            H_START: begin
               // sda falls while scl high
               case (s_ff.q)
                  2'h0: nxt_s.sda_oe = 1'b0;
                  2'h1: nxt_s.scl_oe = 1'b0;
                  2'h2: nxt_s.sda_oe = 1'b1;
                  default: begin
                     nxt_s.scl_oe = 1'b1;
                     nxt_s.state  = H_BYTE;
                     nxt_s.bits   = 4'h0;
                     nxt_s.shift  = addr_byte(s_ff.sel,
                                      s_ff.phase == P_AR);
                  end
               endcase
            end
            H_BYTE: begin
               case (s_ff.q)
                  2'h0: begin
                     if (s_ff.bits != ACK_BIT) begin
                        nxt_s.sda_oe = rx ? 1'b0 : ~s_ff.shift[7];
                     end else begin
                        // read: ack all but the last byte
                        nxt_s.sda_oe = rx & ~last;
                     end
                  end
                  2'h1: nxt_s.scl_oe = 1'b0;
                  2'h2: begin
                     if (s_ff.bits != ACK_BIT) begin
                        nxt_s.shift = {s_ff.shift[6:0],
                                       rx ? sda_lvl : 1'b0};
                     end else if (!rx) begin
                        nxt_s.nack = sda_lvl;
                     end
                  end
                  default: begin
                     nxt_s.scl_oe = 1'b1;
                     nxt_s.bits   = s_ff.bits + 4'h1;
                     if (s_ff.bits == ACK_BIT) begin
                        nxt_s.bits = 4'h0;
                        if (s_ff.nack) begin
                           nxt_s.state = H_STOP;
                        end else begin
                           case (s_ff.phase)
                              P_AW: begin
                                 nxt_s.phase = P_REG;
                                 nxt_s.shift = s_ff.reg_a;
                              end
                              P_REG: begin
                                 if (s_ff.rnw) begin
                                    // repeated start to turn
                                    nxt_s.state = H_START;
                                    nxt_s.phase = P_AR;
                                 end else begin
                                    nxt_s.phase = P_WD;
                                    nxt_s.shift = i_wr_data;
                                    nxt_s.take  = 1'b1;
                                 end
                              end
                              P_WD: begin
                                 nxt_s.left = s_ff.left - 8'h01;
                                 if (last) begin
                                    nxt_s.state = H_STOP;
                                 end else begin
                                    nxt_s.shift = i_wr_data;
                                    nxt_s.take  = 1'b1;
                                 end
                              end
                              P_AR: nxt_s.phase = P_RD;
                              default: begin
                                 nxt_s.rd_valid = 1'b1;
                                 nxt_s.rd_data  = s_ff.shift;
                                 nxt_s.left     = s_ff.left - 8'h01;
                                 if (last) begin
                                    nxt_s.state = H_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               // sda rises while scl high
               case (s_ff.q)
                  2'h0: nxt_s.sda_oe = 1'b1;
                  2'h1: nxt_s.scl_oe = 1'b0;
                  2'h2: nxt_s.sda_oe = 1'b0;
                  default: begin
                     nxt_s.state = H_IDLE;
                     nxt_s.busy  = 1'b0;
                     nxt_s.done  = 1'b1;
                  end
               endcase
            end
            default: nxt_s.state = H_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s_ff       <= '0;
         s_ff.state <= H_IDLE;
         s_ff.phase <= P_AW;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // open drain: only ever pull low
   assign bus.host_scl_out = 1'b0;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_scl_oe  = s_ff.scl_oe;
   assign bus.host_sda_oe  = s_ff.sda_oe;

   assign o_busy     = s_ff.busy;
   assign o_done     = s_ff.done;
   assign o_nack     = s_ff.nack;
   assign o_wr_take  = s_ff.take;
   assign o_rd_valid = s_ff.rd_valid;
   assign o_rd_data  = s_ff.rd_data;
endmodule // disp_port_host

// ---- src/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_reset,
   // raw pins
   input  wire logic [WIDTH-1:0] i_pin,
   // synchronised level and edges
   output logic      [WIDTH-1:0] o_level,
   output logic      [WIDTH-1:0] o_rise,
   output logic      [WIDTH-1:0] o_fall
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] prev;
      logic [1:0]       age;
   } sync_ff_t;

   sync_ff_t s_ff;
   sync_ff_t nxt_s;
   logic     warm;

   // meta feeds only level; edges look at level and prev
   always_comb begin
      nxt_s       = s_ff;
      nxt_s.meta  = i_pin;
      nxt_s.level = s_ff.meta;
      nxt_s.prev  = s_ff.level;
      nxt_s.age   = (s_ff.age == 2'h3) ? s_ff.age : s_ff.age + 2'h1;
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_level = s_ff.level;
   // edges held off until prev holds a real sample, so the
   // cleared flops after reset never read as a pin edge
   assign warm    = (s_ff.age == 2'h3);
   assign o_rise  = {WIDTH{warm}} & s_ff.level & ~s_ff.prev;
   assign o_fall  = {WIDTH{warm}} & ~s_ff.level & s_ff.prev;
endmodule // pin_sync

// ---- testbench/disp_port_properties.sv ----
`timescale 1ns/1ps
module disp_port_checker
   import dsp_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_reset,
   // link wires and drivers
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic host_scl_oe,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_oe,
   // device pins
   input  wire logic i_addr_select_pin,
   input  wire logic i_pin_reset_low
);
   logic       scl_q;
   logic       sda_q;
   logic       rd_xfer;
   logic       matched;
   logic       nacked;
   logic [3:0] bitn;
   logic [3:0] byten;
   logic [7:0] sr;
   logic [8:0] gap;
   logic       rise;
   logic       start;
   logic       ack_rise;
   logic       match;

   // wire events seen at the system clock
   assign rise     = scl & ~scl_q;
   assign start    = scl & scl_q & sda_q & ~sda;
   assign ack_rise = rise & (bitn == 4'h8);
   assign match    = (sr[7:1] == {ADDR_HI, i_addr_select_pin});

   // light bus decoder; bit count restarts at every start condition
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         gap     <= 9'h1ff;
         bitn    <= 4'h0;
         byten   <= 4'h0;
         sr      <= 8'h00;
         rd_xfer <= 1'b0;
         matched <= 1'b0;
         nacked  <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         gap   <= rise ? 9'h000 : ((gap == 9'h1ff) ? gap : gap + 9'h001);
         if (start) begin
            bitn   <= 4'h0;
            byten  <= 4'h0;
            nacked <= 1'b0;
         end else if (ack_rise) begin
            bitn   <= 4'h0;
            nacked <= sda;
            if (byten != 4'hf) byten <= byten + 4'h1;
            if (byten == 4'h0) begin
               rd_xfer <= sr[0];
               matched <= match & i_pin_reset_low;
            end
         end else if (rise) begin
            bitn <= bitn + 4'h1;
            sr   <= {sr[6:0], sda};
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   chk_scl_host_only: assert property (scl == ~host_scl_oe)
      else $error("scl level not set by the host alone");
   chk_addr_match_ack: assert property (
      ack_rise && byten == 4'h0 && match && i_pin_reset_low |-> dev_sda_oe)
      else $error("matching address not acknowledged");
   chk_addr_miss_quiet: assert property (
      ack_rise && byten == 4'h0 && !match |-> !dev_sda_oe)
      else $error("foreign address acknowledged");
   chk_write_byte_ack: assert property (
      ack_rise && byten != 4'h0 && matched && !rd_xfer |-> dev_sda_oe)
      else $error("write byte not acknowledged");
   chk_read_ack_free: assert property (
      ack_rise && byten != 4'h0 && matched && rd_xfer |-> !dev_sda_oe)
      else $error("device holds sda in host ack slot");
   chk_read_host_free: assert property (
      rise && bitn != 4'h8 && byten != 4'h0 && matched && rd_xfer && !nacked
      |-> !host_sda_oe)
      else $error("host pulls sda during read data");
   chk_scl_rate: assert property (rise |-> gap >= 9'd249)
      else $error("scl period below limit");
   chk_reset_pin_quiet: assert property (
      !i_pin_reset_low [*8] |-> !dev_sda_oe)
      else $error("device drives sda while reset pin low");
   chk_sda_moves_low: assert property (
      $changed(dev_sda_oe) |-> !scl)
      else $error("device changed sda while scl high");

   // main traffic kinds
   cov_write_ack: cover property (ack_rise && byten == 4'h2 && !rd_xfer);
   cov_read_data: cover property (rise && rd_xfer && matched && byten == 4'h3);
   cov_addr_nack: cover property (ack_rise && byten == 4'h0 && !match);
endmodule // disp_port_checker

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
   import dsp_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic        go = 1'b0;
   logic        rnw = 1'b0;
   logic        sel = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  len = 8'h01;
   logic [7:0]  wr_data = 8'h00;
   logic        addr_pin = 1'b0;
   logic        pin_rst_n = 1'b1;
   logic        sleep_req = 1'b0;
   logic        h_busy, h_done, h_nack, h_take, h_rvalid;
   logic [7:0]  h_rdata;
   logic        d_wr, d_sleep, d_busy;
   logic [7:0]  d_addr, d_data;
   logic [7:0]  rq[$];
   logic [15:0] mq[$];
   int          mismatches = 0;
   int          compares = 0;

   serial_if bus_if ();

   // both ends face each other on one link
   disp_port_host i_disp_port_host (.i_clock(i_clock), .i_reset(i_reset),
      .bus(bus_if.host), .i_go(go), .i_rnw(rnw), .i_addr_select(sel),
      .i_reg_addr(reg_addr), .i_len(len), .i_wr_data(wr_data),
      .o_busy(h_busy), .o_done(h_done), .o_nack(h_nack),
      .o_wr_take(h_take), .o_rd_valid(h_rvalid), .o_rd_data(h_rdata));
   disp_port_dev i_disp_port_dev (.i_clock(i_clock), .i_reset(i_reset),
      .bus(bus_if.dev), .i_addr_select_pin(addr_pin),
      .i_pin_reset_low(pin_rst_n), .i_sleep_request(sleep_req),
      .o_reg_wr(d_wr), .o_reg_addr(d_addr), .o_reg_data(d_data),
      .o_sleep_active(d_sleep), .o_busy(d_busy));
   disp_port_checker i_disp_port_checker (.i_clock(i_clock),
      .i_reset(i_reset), .scl(bus_if.scl), .sda(bus_if.sda),
      .host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe),
      .dev_sda_oe(bus_if.dev_sda_oe), .i_addr_select_pin(addr_pin),
      .i_pin_reset_low(pin_rst_n));

   always #5 i_clock = ~i_clock;

   // capture pulses mid-cycle, where flop outputs are settled
   always @(negedge i_clock) begin
      if (d_wr === 1'b1) mq.push_back({d_addr, d_data});
      if (h_rvalid === 1'b1) rq.push_back(h_rdata);
   end

   task automatic end_sim;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   // one host command; data byte i is d0 + i*0x11
   task automatic xfer(input logic r, input logic s, input logic [7:0] ra,
                       input logic [7:0] n, input logic [7:0] d0);
      int   k;
      logic [7:0] idx;
      logic take;
      logic dn;
      rq.delete();
      mq.delete();
      idx = 8'h00;
      dn = 1'b0;
      @(posedge i_clock);
      #1;
      rnw = r;
      sel = s;
      reg_addr = ra;
      len = n;
      wr_data = d0;
      go = 1'b1;
      @(posedge i_clock);
      #1;
      go = 1'b0;
      check(h_busy === 1'b1, "command not taken");
      for (k = 0; k < 40000 && !dn; k++) begin
         @(negedge i_clock);
         take = (h_take === 1'b1);
         dn = (h_done === 1'b1);
         @(posedge i_clock);
         #1;
         if (take) begin
            idx = idx + 8'h01;
            wr_data = d0 + idx * 8'h11; // next byte held through its take
         end
      end
      check(dn, "command never completed");
      check(h_busy === 1'b0, "host still busy");
      check(d_busy === 1'b0, "device still busy");
   endtask

   task automatic wr_test(input logic s, input logic [7:0] ra,
                          input logic [7:0] n, input logic [7:0] d0,
                          input logic ok);
      int i;
      xfer(1'b0, s, ra, n, d0);
      check(h_nack === ~ok, "unexpected ack state on write");
      check(mq.size() == (ok ? int'(n) : 0), "stored count");
      for (i = 0; i < mq.size(); i++)
         check(mq[i] === {ra + 8'(i), d0 + 8'(i) * 8'h11},
               "stored byte");
   endtask

   task automatic rd_test(input logic s, input logic [7:0] ra,
                          input logic [7:0] n, input logic [7:0] d0);
      int i;
      xfer(1'b1, s, ra, n, d0);
      check(h_nack === 1'b0, "read refused");
      check(rq.size() == int'(n), "wrong count of read bytes");
      for (i = 0; i < rq.size(); i++)
         check(rq[i] === d0 + 8'(i) * 8'h11, "read byte");
   endtask

   initial begin
      repeat (3) @(posedge i_clock);
      #1;
      i_reset = 1'b0;
      repeat (5) @(posedge i_clock);
      wr_test(1'b0, 8'h10, 8'h03, 8'ha1, 1'b1);
      rd_test(1'b0, 8'h10, 8'h03, 8'ha1);
      rd_test(1'b0, 8'h20, 8'h01, REG_RST);
      #1;
      addr_pin = 1'b1;
      repeat (5) @(posedge i_clock);
      wr_test(1'b1, 8'hff, 8'h02, 8'h5c, 1'b1);
      rd_test(1'b1, 8'hff, 8'h02, 8'h5c);
      wr_test(1'b0, 8'h10, 8'h01, 8'h99, 1'b0);
      #1;
      addr_pin = 1'b0;
      pin_rst_n = 1'b0;
      repeat (5) @(posedge i_clock);
      wr_test(1'b0, 8'h11, 8'h01, 8'h77, 1'b0);
      #1;
      pin_rst_n = 1'b1;
      repeat (5) @(posedge i_clock);
      rd_test(1'b0, 8'h10, 8'h03, 8'ha1);
      #1;
      sleep_req = 1'b1;
      repeat (5) @(posedge i_clock);
      #1;
      check(d_sleep === 1'b1, "sleep not reported");
      wr_test(1'b0, 8'h30, 8'h01, 8'h42, 1'b1);
      rd_test(1'b0, 8'h30, 8'h01, 8'h42);
      sleep_req = 1'b0;
      repeat (5) @(posedge i_clock);
      #1;
      check(d_sleep === 1'b0, "sleep not left");
      end_sim();
   end

   // the command list needs about 95000 cycles
   initial begin
      #1200000;
      mismatches++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
endmodule // tb
